// file: fatc_params.svh
`ifndef FATC_PARAMS_SVH
`define FATC_PARAMS_SVH
`define FATC_ADDR_CTRL 8'h00
`define FATC_ADDR_CMD 8'h04
`define FATC_ADDR_EXPO 8'h08
`define FATC_ADDR_READOUT 8'h0C
`define FATC_ADDR_PERIOD 8'h10
`define FATC_ADDR_COUNT 8'h14
`define FATC_ADDR_STATUS 8'h18
`define FATC_CTRL_MODE_LSB 0
`define FATC_CTRL_TRIG_ON 2
`define FATC_CTRL_SRC_EXT 3
`define FATC_CTRL_FALLING 4
`define FATC_CTRL_WIDTH 5
`define FATC_CMD_START 0
`define FATC_CMD_STOP 1
`define FATC_CMD_SOFT 2
`define FATC_RST_EXPO 32'h000003E8
`define FATC_RST_READOUT 32'h00000100
`define FATC_RST_PERIOD 32'h00001000
`define FATC_RST_COUNT 8'h01
`define FATC_SETUP_CYCLES 32'h00000010
`define FATC_MIN_PULSE_NS 1000
`define FATC_CLK_MHZ 200
`define FATC_MIN_PULSE_CYC ((`FATC_MIN_PULSE_NS * `FATC_CLK_MHZ + 999) / 1000)
`endif

// file: fatc_pkg.sv
package fatc_pkg;
  typedef enum logic [1:0] {
    FATC_SINGLE_type_val = 2'h0,
    FATC_MULTI_type_val = 2'h1,
    FATC_CONT_type_val = 2'h2
  } fatc_acqmode_type;
  typedef struct packed {
    logic [2:0] cmd;
    logic [31:0] data;
  } fatc_cmd_type;
endpackage

// file: fatc_top.sv
`timescale 1ns/1ps
`include "fatc_params.svh"
// Notes on behaviour
// - No frame is acquired until a start command is in effect.
// - Single-frame mode disarms itself after one frame completes.
// - Continuous mode stays armed over frames until stop.
// - Stop while waiting disarms at once.
// - Stop during a frame lets it finish, then disarms.
// - Multi-frame stops after accepted triggers equal programmed count.
// - Accepted trigger leaves waiting, exposes, then reads out a frame.
// - Waiting state returns as soon as a new trigger can be accepted.
// - Trigger off: an internal period generator makes triggers.
// - Triggers outside the waiting state are discarded.
// - Trigger on: each accepted source trigger starts exactly one frame.
// - Software source: each soft command is one trigger.
// - External source: each valid edge is one trigger.
// - External timed mode exposes for the programmed time.
// - External width mode exposes while the pulse is active.
// - Continuous mode: each accepted trigger acquires and sends a frame.
// - Single-frame mode runs a 16-cycle setup phase before each frame.
// - External pulses shorter than one microsecond are ignored.
// - Polarity setting picks rising or falling edge as start.
module fatc_top (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [3:0] I_WB_SEL,
  input wire logic I_WB_WE,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic I_TRIG,
  output logic O_EXPOSE,
  output logic O_READOUT,
  output logic O_FRAME_DONE,
  output logic O_ARMED
);
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_WAIT, ST_EXPOSE, ST_READ} fatc_state_type;

  ////////////////////////////////////////////////////////////////////////
  // Register bus.
  logic [31:0] ctrl_reg, expo_reg, read_reg, period_reg;
  logic [7:0] count_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic err_reg;
  wire acc = I_WB_CYC && I_WB_STB && !ack_reg;
  wire wr = acc && I_WB_WE;
  wire wr_cmd = wr && (I_WB_ADR == `FATC_ADDR_CMD) && I_WB_SEL[0];
  wire cmd_start = wr_cmd && I_WB_DAT[`FATC_CMD_START];
  wire cmd_stop = wr_cmd && I_WB_DAT[`FATC_CMD_STOP];
  wire cmd_soft = wr_cmd && I_WB_DAT[`FATC_CMD_SOFT];
  wire [1:0] mode = ctrl_reg[`FATC_CTRL_MODE_LSB +: 2];
  wire trig_on = ctrl_reg[`FATC_CTRL_TRIG_ON];
  wire src_ext = ctrl_reg[`FATC_CTRL_SRC_EXT];
  wire width_mode = ctrl_reg[`FATC_CTRL_WIDTH] && src_ext;

  // Byte-lane merge, used by the control, exposure, readout and period words.
  function automatic logic [31:0] lane(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    lane = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        lane[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  fatc_state_type state_reg, state_next;
  logic armed_reg, stop_pend_reg;
  logic [7:0] taken_reg;
  logic [31:0] tmr_reg, gen_reg;
  // Status word: state in [2:0], flags in [6:4], frames taken in [14:7]; bit 3 reads zero.
  wire [31:0] status_w = {17'h00000, taken_reg, err_reg, stop_pend_reg, armed_reg, 1'b0, state_reg};
  wire [31:0] rmux =
    (I_WB_ADR == `FATC_ADDR_CTRL) ? ctrl_reg :
    (I_WB_ADR == `FATC_ADDR_EXPO) ? expo_reg :
    (I_WB_ADR == `FATC_ADDR_READOUT) ? read_reg :
    (I_WB_ADR == `FATC_ADDR_PERIOD) ? period_reg :
    (I_WB_ADR == `FATC_ADDR_COUNT) ? {24'h000000, count_reg} :
    (I_WB_ADR == `FATC_ADDR_STATUS) ? status_w : 32'h00000000;

  // Ack one cycle after the request; unmapped addresses read zero.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else begin
      ack_reg <= acc;
      rdat_reg <= rmux;
    end
  end
  assign O_WB_ACK = ack_reg;
  assign O_WB_DAT = rdat_reg;

  // Configuration words.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_reg <= 32'h00000000;
      expo_reg <= `FATC_RST_EXPO;
      read_reg <= `FATC_RST_READOUT;
      period_reg <= `FATC_RST_PERIOD;
      count_reg <= `FATC_RST_COUNT;
    end else if (wr) begin
      if (I_WB_ADR == `FATC_ADDR_CTRL) ctrl_reg <= lane(ctrl_reg, I_WB_DAT, I_WB_SEL) & 32'h0000003F;
      if (I_WB_ADR == `FATC_ADDR_EXPO) expo_reg <= lane(expo_reg, I_WB_DAT, I_WB_SEL);
      if (I_WB_ADR == `FATC_ADDR_READOUT) read_reg <= lane(read_reg, I_WB_DAT, I_WB_SEL);
      if (I_WB_ADR == `FATC_ADDR_PERIOD) period_reg <= lane(period_reg, I_WB_DAT, I_WB_SEL);
      if (I_WB_ADR == `FATC_ADDR_COUNT && I_WB_SEL[0]) count_reg <= I_WB_DAT[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // External trigger: synchroniser, polarity, and width filter.
  logic sync1_reg, sync2_reg;
  logic [15:0] hi_cnt_reg;
  wire act_lvl = sync2_reg ^ ctrl_reg[`FATC_CTRL_FALLING];
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= I_TRIG;
      sync2_reg <= sync1_reg;
    end
  end

  // A pulse becomes a trigger only once it has stood for the minimum width; the trade is a fixed one-microsecond latency.
  wire ext_fire = act_lvl && (hi_cnt_reg == 16'(`FATC_MIN_PULSE_CYC - 1));
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      hi_cnt_reg <= 16'h0000;
    end else begin
      hi_cnt_reg <= act_lvl ? ((hi_cnt_reg == 16'hFFFF) ? hi_cnt_reg : hi_cnt_reg + 16'h0001) : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger selection; the internal generator counts only while waiting.
  wire gen_fire = (state_reg == ST_WAIT) && (gen_reg >= period_reg - 32'h1);
  wire trig_any = !trig_on ? gen_fire : (src_ext ? ext_fire : cmd_soft);
  wire multi_full = (mode == 2'(fatc_pkg::FATC_MULTI_type_val)) && (taken_reg >= count_reg);
  wire accept = (state_reg == ST_WAIT) && trig_any && !multi_full && !cmd_stop;
  wire tmr_done = (tmr_reg == 32'h0);
  wire expo_end = width_mode ? !act_lvl : tmr_done;
  wire single = (mode == 2'(fatc_pkg::FATC_SINGLE_type_val));
  wire last_frame = single || multi_full || stop_pend_reg || cmd_stop;

  // Sequencer next state.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (cmd_start) state_next = single ? ST_SETUP : ST_WAIT;
      ST_SETUP: if (tmr_done) state_next = ST_WAIT;
      ST_WAIT: begin
        if (cmd_stop || multi_full) state_next = ST_IDLE;
        else if (accept) state_next = ST_EXPOSE;
      end
      ST_EXPOSE: if (expo_end) state_next = ST_READ;
      ST_READ: if (tmr_done) state_next = last_frame ? ST_IDLE : ST_WAIT;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Phase timer: loaded on entry to setup, exposure and readout.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      tmr_reg <= 32'h0;
    end else if (state_reg == ST_IDLE && state_next == ST_SETUP) begin
      tmr_reg <= `FATC_SETUP_CYCLES - 32'h1;
    end else if (accept) begin
      tmr_reg <= (expo_reg == 32'h0) ? 32'h0 : expo_reg - 32'h1;
    end else if (state_reg == ST_EXPOSE && expo_end) begin
      tmr_reg <= (read_reg == 32'h0) ? 32'h0 : read_reg - 32'h1;
    end else if (!tmr_done) begin
      tmr_reg <= tmr_reg - 32'h1;
    end
  end

  // Internal generator and frame accounting.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      gen_reg <= 32'h0;
      taken_reg <= 8'h00;
      stop_pend_reg <= 1'b0;
      err_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      gen_reg <= (state_reg == ST_WAIT && !gen_fire) ? gen_reg + 32'h1 : 32'h0;
      if (state_reg == ST_IDLE && cmd_start) taken_reg <= 8'h00;
      else if (accept) taken_reg <= taken_reg + 8'h01;
      if (state_next == ST_IDLE) stop_pend_reg <= 1'b0;
      else if (cmd_stop) stop_pend_reg <= 1'b1;
      // Restart during a frame is dropped; it is flagged in single and multi-frame modes, and a status write with bit 3 set clears the flag.
      if (cmd_start && (state_reg == ST_EXPOSE || state_reg == ST_READ) && !mode[1]) err_reg <= 1'b1;
      else if (wr && I_WB_ADR == `FATC_ADDR_STATUS && I_WB_DAT[3]) err_reg <= 1'b0;
      armed_reg <= (state_next != ST_IDLE);
    end
  end

  // Sensor-facing outputs, all registered.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_EXPOSE <= 1'b0;
      O_READOUT <= 1'b0;
      O_FRAME_DONE <= 1'b0;
    end else begin
      O_EXPOSE <= (state_next == ST_EXPOSE);
      O_READOUT <= (state_next == ST_READ);
      O_FRAME_DONE <= (state_reg == ST_READ) && tmr_done;
    end
  end
  assign O_ARMED = armed_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_no_frame_unarmed;
    @(posedge I_CLK) disable iff (I_RST) (state_reg == ST_IDLE && !cmd_start) |=> (state_reg == ST_IDLE);
  endproperty
  a_no_frame_unarmed: assert property (p_no_frame_unarmed) else $error("frame left idle without start");
  property p_single_disarm;
    @(posedge I_CLK) disable iff (I_RST) (state_reg == ST_READ && tmr_done && single) |=> state_reg == ST_IDLE;
  endproperty
  a_single_disarm: assert property (p_single_disarm) else $error("single frame did not disarm");
  property p_stop_idle;
    @(posedge I_CLK) disable iff (I_RST) (state_reg == ST_WAIT && cmd_stop) |=> state_reg == ST_IDLE ##1 !O_ARMED;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop while waiting not immediate");
  property p_stop_frame;
    @(posedge I_CLK) disable iff (I_RST) (state_reg == ST_EXPOSE && cmd_stop) |=> state_reg != ST_IDLE;
  endproperty
  a_stop_frame: assert property (p_stop_frame) else $error("frame cut short by stop");
  property p_multi_count;
    @(posedge I_CLK) disable iff (I_RST)
      (state_reg == ST_READ && tmr_done && mode == 2'h1 && taken_reg == count_reg) |=> state_reg == ST_IDLE;
  endproperty
  a_multi_count: assert property (p_multi_count) else $error("trigger beyond frame count");
  sequence s_accept;
    state_reg == ST_WAIT && accept;
  endsequence
  property p_accept_expose;
    @(posedge I_CLK) disable iff (I_RST) s_accept |=> state_reg == ST_EXPOSE && O_EXPOSE;
  endproperty
  a_accept_expose: assert property (p_accept_expose) else $error("accepted trigger did not expose");
  property p_discard;
    @(posedge I_CLK) disable iff (I_RST) (state_reg == ST_EXPOSE && trig_any && !expo_end) |=> state_reg == ST_EXPOSE;
  endproperty
  a_discard: assert property (p_discard) else $error("trigger acted outside wait");
  property p_cont_rearm;
    @(posedge I_CLK) disable iff (I_RST)
      (state_reg == ST_READ && tmr_done && !last_frame) |=> state_reg == ST_WAIT;
  endproperty
  a_cont_rearm: assert property (p_cont_rearm) else $error("did not return to wait");
  property p_width;
    @(posedge I_CLK) disable iff (I_RST) (state_reg == ST_EXPOSE && width_mode && act_lvl) |=> state_reg == ST_EXPOSE;
  endproperty
  a_width: assert property (p_width) else $error("width exposure ended early");
  property p_start_clear;
    @(posedge I_CLK) disable iff (I_RST) (state_reg == ST_IDLE && cmd_start) |=> taken_reg == 8'h00;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("counter not cleared on start");
  sequence s_single_start;
    state_reg == ST_IDLE && cmd_start && single;
  endsequence
  property p_setup_first;
    @(posedge I_CLK) disable iff (I_RST) s_single_start |=> state_reg == ST_SETUP;
  endproperty
  a_setup_first: assert property (p_setup_first) else $error("single start skipped setup");
  sequence s_soft_take;
    state_reg == ST_WAIT && trig_on && !src_ext && cmd_soft && !cmd_stop && !multi_full;
  endsequence
  property p_soft_trig;
    @(posedge I_CLK) disable iff (I_RST) s_soft_take |=> state_reg == ST_EXPOSE && O_EXPOSE;
  endproperty
  a_soft_trig: assert property (p_soft_trig) else $error("soft trigger did not start a frame");
  // Independent run length of the active level, so the filter is not checked against itself.
  logic [15:0] lvl_run_reg;
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      lvl_run_reg <= 16'h0000;
    end else begin
      lvl_run_reg <= act_lvl ? lvl_run_reg + {15'h0000, lvl_run_reg != 16'hFFFF} : 16'h0000;
    end
  end
  property p_min_pulse;
    @(posedge I_CLK) disable iff (I_RST)
      (accept && trig_on && src_ext) |-> lvl_run_reg >= 16'(`FATC_MIN_PULSE_CYC - 1);
  endproperty
  a_min_pulse: assert property (p_min_pulse) else $error("external pulse accepted too short");
  property p_done_pulse;
    @(posedge I_CLK) disable iff (I_RST) (state_reg == ST_READ && tmr_done) |=> O_FRAME_DONE && !O_READOUT;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("frame end not signalled");
endmodule

// file: fatc_trig_src.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// External trigger source seen through the opto input: the line always rests at a defined level.
module fatc_trig_src (
  input wire logic i_clk,
  output logic o_trig
);
  initial o_trig = 1'b0;

  // Moves the resting level of the line; only used while acquisition is stopped.
  task automatic set_idle(input logic lvl);
    @(posedge i_clk);
    o_trig <= lvl;
  endtask

  // One pulse of a given width, then a long quiet gap so the trigger rate stays legal.
  task automatic pulse(input int width, input logic act);
    @(posedge i_clk);
    o_trig <= act;
    repeat (width) @(posedge i_clk);
    o_trig <= ~act;
    repeat (400) @(posedge i_clk);
  endtask
endmodule

// file: tb.sv
`timescale 1ns/1ps
`include "fatc_params.svh"
////////////////////////////////////////////////////////////////////////////////
module tb;
  logic I_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic [31:0] rdat;
  logic ack, trig, expose, readout, done, armed;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0, elen = 0, rlen = 0, tol = 0, e, i;
  logic [31:0] rq[$];
  int fq[$];

  // Free-running system clock.
  always #2.5 I_CLK = ~I_CLK;

  fatc_top u_fatc_top (.I_CLK(I_CLK), .I_RST(I_RST), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(sel),
    .I_WB_WE(we), .I_WB_CYC(cyc), .I_WB_STB(stb), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_TRIG(trig),
    .O_EXPOSE(expose), .O_READOUT(readout), .O_FRAME_DONE(done), .O_ARMED(armed));
  fatc_trig_src u_fatc_trig_src (.i_clk(I_CLK), .o_trig(trig));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Classic single cycle; the request is held until ack is seen high at an edge.
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w);
    int n;
    @(posedge I_CLK);
    adr <= a; wdat <= d; we <= w; sel <= 4'hF; cyc <= 1'b1; stb <= 1'b1;
    n = 0;
    do begin @(posedge I_CLK); n++; end while (ack !== 1'b1 && n < 50);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n == 50) chk(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rq.push_back(x);
    wb(a, 32'h0, 1'b0);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge I_CLK);
  endtask

  // The monitor drains the queue, so waiting on its size is a bounded wait for the frames.
  task automatic wait_frames();
    for (int k = 0; k < 3000 && fq.size() > 0; k++) @(posedge I_CLK);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watches read data and frames; an unexpected frame finds no note and counts as a mismatch.
  always @(posedge I_CLK) begin
    if (ack === 1'b1 && we === 1'b0) chk(rdat, rq.pop_front());
    if (expose === 1'b1) elen++;
    if (readout === 1'b1) rlen++;
    if (done === 1'b1) begin
      samples_checked++;
      if (fq.size() == 0 || elen > fq[0] + tol || elen + tol < fq[0]) begin
        miscompares++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, elen, fq.size() ? fq[0] : 0);
      end
      if (fq.size() > 0) void'(fq.pop_front());
      chk(rlen, 32'h0000000A);
      elen = 0;
      rlen = 0;
    end
  end

  // Cuts a hang short well above the expected run length.
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(6));
    settle(5);
    I_RST <= 1'b0;
    settle(1);
    chk({expose, readout, done, armed}, 32'h0);
    rd(`FATC_ADDR_STATUS, 32'h0);
    rd(`FATC_ADDR_EXPO, `FATC_RST_EXPO);
    rd(`FATC_ADDR_READOUT, `FATC_RST_READOUT);
    rd(`FATC_ADDR_PERIOD, `FATC_RST_PERIOD);
    rd(`FATC_ADDR_COUNT, {24'h0, `FATC_RST_COUNT});
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0);
    e = 8 + ($urandom % 24);
    wr(`FATC_ADDR_EXPO, e);
    wr(`FATC_ADDR_READOUT, 32'h0000000A);
    wr(`FATC_ADDR_PERIOD, 32'h0000003C);
    // Software triggers before any start must not make a frame.
    wr(`FATC_ADDR_CTRL, 32'h4);
    wr(`FATC_ADDR_CMD, 32'h4);
    settle(100);
    chk(armed, 32'h0);
    // Single frame: one soft trigger, then the block disarms itself.
    wr(`FATC_ADDR_CMD, 32'h1);
    settle(30);
    chk(armed, 32'h1);
    fq.push_back(e);
    wr(`FATC_ADDR_CMD, 32'h4);
    wait_frames();
    settle(5);
    chk(armed, 32'h0);
    wr(`FATC_ADDR_CMD, 32'h4);
    settle(60);
    // Continuous with internal triggers; stop lands during the fourth exposure.
    wr(`FATC_ADDR_CTRL, 32'h2);
    repeat (4) fq.push_back(e);
    wr(`FATC_ADDR_CMD, 32'h1);
    for (i = 0; i < 3000 && !(fq.size() == 1 && expose === 1'b1); i++) @(posedge I_CLK);
    chk(armed, 32'h1);
    wr(`FATC_ADDR_CMD, 32'h2);
    wait_frames();
    settle(200);
    chk(armed, 32'h0);
    // Stop while waiting disarms at once; a later soft trigger is dropped.
    wr(`FATC_ADDR_CTRL, 32'h6);
    wr(`FATC_ADDR_CMD, 32'h1);
    settle(5);
    wr(`FATC_ADDR_CMD, 32'h2);
    wr(`FATC_ADDR_CMD, 32'h4);
    settle(60);
    chk(armed, 32'h0);
    // Multi-frame with a count of two; extra triggers during exposure are dropped.
    wr(`FATC_ADDR_COUNT, 32'h2);
    wr(`FATC_ADDR_CTRL, 32'h5);
    wr(`FATC_ADDR_CMD, 32'h1);
    for (i = 0; i < 3; i++) begin
      if (i < 2) fq.push_back(e);
      wr(`FATC_ADDR_CMD, 32'h4);
      wr(`FATC_ADDR_CMD, 32'h4);
      settle(e + 30);
    end
    chk(armed, 32'h0);
    rd(`FATC_ADDR_STATUS, 32'h00000100);
    // A new start only once the block is idle again.
    wr(`FATC_ADDR_CMD, 32'h1);
    fq.push_back(e);
    wr(`FATC_ADDR_CMD, 32'h4);
    wait_frames();
    wr(`FATC_ADDR_CMD, 32'h2);
    // External rising edge, timed exposure; a short pulse must be ignored.
    wr(`FATC_ADDR_CTRL, 32'hE);
    wr(`FATC_ADDR_CMD, 32'h1);
    u_fatc_trig_src.pulse(100, 1'b1);
    fq.push_back(e);
    u_fatc_trig_src.pulse(250, 1'b1);
    wait_frames();
    // Width exposure follows the pulse, less the recognition delay.
    wr(`FATC_ADDR_CMD, 32'h2);
    wr(`FATC_ADDR_CTRL, 32'h2E);
    wr(`FATC_ADDR_CMD, 32'h1);
    tol = 6;
    fq.push_back(100);
    u_fatc_trig_src.pulse(300, 1'b1);
    wait_frames();
    tol = 0;
    // Falling-edge polarity with the line resting high.
    wr(`FATC_ADDR_CMD, 32'h2);
    u_fatc_trig_src.set_idle(1'b1);
    wr(`FATC_ADDR_CTRL, 32'h1E);
    wr(`FATC_ADDR_CMD, 32'h1);
    fq.push_back(e);
    u_fatc_trig_src.pulse(250, 1'b0);
    wait_frames();
    wr(`FATC_ADDR_CMD, 32'h2);
    settle(20);
    chk(fq.size(), 32'h0);
    complete_run();
  end
endmodule
